// ---- shared/fps_pkg.sv ----
package fps_pkg;
	// ****************************************************************
	// widths and sizes
	// ****************************************************************
	localparam int PC_W        = 12;
	localparam int PC_LO_W     = 8;
	localparam int IR_W        = 16;
	localparam int STACK_DEPTH = 6;
	localparam int SP_W        = 3;
	localparam int PH_W        = 2;
	localparam int APB_AW      = 8;

	// ****************************************************************
	// register map and field positions
	// ****************************************************************
	localparam logic [7:0]  OFS_PC_LO     = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam int          STAT_PEND_BIT = 12;
	localparam int          STAT_EXEC_BIT = 13;

	// ****************************************************************
	// reset and interrupt vectors, phase codes
	// ****************************************************************
	localparam logic [11:0] RESET_VECTOR  = 12'h000;
	localparam logic [11:0] INT_VECTOR    = 12'h004;
	localparam logic [1:0]  PH_FETCH      = 2'h0;
	localparam logic [1:0]  PH_LAST       = 2'h3;

	// sequencer states
	typedef enum logic [1:0] {
		FPS_RUN,
		FPS_EXT2,
		FPS_INT2
	} fps_seq_e;
endpackage

// ---- hw/fps_phase_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module fps_phase_gen (
	input  wire logic                    pclk,     // system clock
	input  wire logic                    presetn,  // async reset, low
	output logic [fps_pkg::PH_W-1:0]     ph_cnt_ff, // phase index 0..3
	output logic [3:0]                   phase_ff  // one-hot phase clocks
);
	logic [fps_pkg::PH_W-1:0] nxt_ph_cnt;
	logic [3:0]               nxt_phase;

	// phases advance every edge; one-hot keeps them non-overlapping
	always_comb begin
		nxt_ph_cnt = ph_cnt_ff + 2'h1;
		nxt_phase  = {phase_ff[2:0], phase_ff[3]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_cnt_ff <= 2'h0;
			phase_ff  <= 4'h1;
		end else begin
			ph_cnt_ff <= nxt_ph_cnt;
			phase_ff  <= nxt_phase;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_phase_ring_wraps: assert property (ph_cnt_ff == fps_pkg::PH_LAST |=>
		ph_cnt_ff == fps_pkg::PH_FETCH && phase_ff == 4'h1)
		else $error("phase ring did not wrap to fetch phase");
endmodule
`default_nettype wire

// ---- hw/fps_ret_stack.sv ----
`timescale 1ns/1ps
`default_nettype none
module fps_ret_stack #(
	parameter int DEPTH = fps_pkg::STACK_DEPTH,
	parameter int W     = fps_pkg::PC_W
) (
	input  wire logic         pclk,     // system clock
	input  wire logic         presetn,  // async reset, low
	input  wire logic         push,     // save din on top
	input  wire logic         pop,      // drop top entry
	input  wire logic [W-1:0] din,      // value to save
	output logic [W-1:0]      top,      // newest entry
	output logic              full      // all levels used
);
	logic [W-1:0]             mem_ff [DEPTH];
	logic [W-1:0]             nxt_mem [DEPTH];
	logic [fps_pkg::SP_W-1:0] depth_ff;
	logic [fps_pkg::SP_W-1:0] nxt_depth;

	// shift organisation: a push onto a full stack drops the oldest entry
	always_comb begin
		nxt_mem   = mem_ff;
		nxt_depth = depth_ff;
		if (push) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				nxt_mem[i] = mem_ff[i-1];
			end
			nxt_mem[0] = din;
			if (depth_ff != fps_pkg::SP_W'(DEPTH)) begin
				nxt_depth = depth_ff + 3'h1;
			end
		end else if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				nxt_mem[i] = mem_ff[i+1];
			end
			if (depth_ff != 3'h0) begin
				nxt_depth = depth_ff - 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			depth_ff <= 3'h0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else begin
			depth_ff <= nxt_depth;
			mem_ff   <= nxt_mem;
		end
	end

	assign top  = mem_ff[0];
	assign full = (depth_ff == fps_pkg::SP_W'(DEPTH));

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_push_saves_top: assert property (push |=> top == $past(din))
		else $error("pushed value not on top of stack");
	a_full_push_keeps: assert property (full && push |=> full)
		else $error("push on full stack changed fullness");
endmodule
`default_nettype wire

// ---- hw/fps_fetch_seq.sv ----
// Function
// - derive four non-overlapping phases; four phases make one instruction cycle.
// - advance program counter at fetch phase start and fetch during it.
// - phases two to four decode and execute the instruction.
// - prefetch next instruction during execution; one per cycle.
// - standard one cycle, extended two, branch adds one.
// - counter-changing instructions take one extra cycle for the target.
// - counter increments by one unless a non-consecutive transfer happens.
// - jump, call, interrupt or reset loads target into counter.
// - met skip discards prefetched instruction and runs a dummy cycle.
// - counter is twelve bits; only the low byte is software visible. Here the status register also returns all twelve bits.
// - low byte readable, writable; write jumps within current 256 page.
// - software low-byte write inserts a dummy cycle for prefetch.
// - six-level counter-only stack, hidden from software with its pointer.
// - call or interrupt acknowledge pushes the counter.
// - return instructions restore the counter from the stack top.
// - after reset the stack holds no return addresses.
// - instruction operations use an eight-bit datapath.
// - reset loads address zero and execution starts there.
// - stack full withholds interrupt acknowledge until a return pops.
// - call on full stack proceeds, losing the earliest saved value.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fps_fetch_seq #(
	parameter logic [11:0] INT_VEC = fps_pkg::INT_VECTOR  // service vector
) (
	input  wire logic                        pclk,          // system clock
	input  wire logic                        presetn,       // async reset, low
	input  wire logic                        psel,          // apb select
	input  wire logic                        penable,       // apb enable
	input  wire logic                        pwrite,        // apb direction
	input  wire logic [fps_pkg::APB_AW-1:0]  paddr,         // apb byte address
	input  wire logic [31:0]                 pwdata,        // apb write data
	output logic [31:0]                      prdata_ff,     // apb read data
	output logic                             pready_ff,     // apb ready
	output logic                             pslverr_ff,    // apb error
	output logic [fps_pkg::PC_W-1:0]         pc_ff,         // fetch address
	output logic                             pm_rd_ff,      // fetch strobe
	input  wire logic [fps_pkg::IR_W-1:0]    pm_data,       // fetched word
	output logic [fps_pkg::IR_W-1:0]         ir_ff,         // executing word
	output logic                             exec_valid_ff, // ir is real
	output logic                             int_ack_ff,    // interrupt taken
	output logic [3:0]                       phase_ff,      // phase clocks
	input  wire logic                        dec_ext,       // extended instr
	input  wire logic                        dec_jump,      // jump_instruction
	input  wire logic                        dec_call,      // subroutine call
	input  wire logic                        dec_ret,       // return instr
	input  wire logic                        dec_skip,      // skip condition met
	input  wire logic [fps_pkg::PC_W-1:0]    dec_target,    // branch target
	input  wire logic                        int_req        // enabled request
);
	// ****************************************************************
	// phase generation and return stack
	// ****************************************************************
	logic [fps_pkg::PH_W-1:0] ph_cnt;
	logic                     stk_push;
	logic                     stk_pop;
	logic [fps_pkg::PC_W-1:0] stk_din;
	logic [fps_pkg::PC_W-1:0] stk_top;
	logic                     stk_full;

	fps_phase_gen u_phase (
		.pclk      (pclk),
		.presetn   (presetn),
		.ph_cnt_ff (ph_cnt),
		.phase_ff  (phase_ff)
	);

	fps_ret_stack #(
		.DEPTH (fps_pkg::STACK_DEPTH),
		.W     (fps_pkg::PC_W)
	) u_stack (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (stk_push),
		.pop     (stk_pop),
		.din     (stk_din),
		.top     (stk_top),
		.full    (stk_full)
	);

	// ****************************************************************
	// apb slave
	// ****************************************************************
	logic                     apb_setup;
	logic                     pc_lo_wr;
	logic                     pc_lo_pend_ff;
	logic [fps_pkg::PC_LO_W-1:0] pc_lo_val_ff;
	logic                     nxt_pc_lo_pend;
	logic [fps_pkg::PC_LO_W-1:0] nxt_pc_lo_val;
	logic [31:0]              nxt_prdata;
	logic                     nxt_pready;
	logic                     nxt_pslverr;
	logic                     ph_last;
	logic                     pend_taken;

	assign apb_setup = psel && !penable;
	assign pc_lo_wr  = psel && penable && pready_ff && pwrite && (paddr == fps_pkg::OFS_PC_LO);
	assign ph_last   = (ph_cnt == fps_pkg::PH_LAST);

	// zero wait states: ready is raised for the access cycle of every transfer
	always_comb begin
		nxt_pready  = apb_setup;
		nxt_pslverr = 1'b0;
		nxt_prdata  = 32'h0;
		if (apb_setup) begin
			case (paddr)
				fps_pkg::OFS_PC_LO: nxt_prdata = {24'h0, pc_ff[fps_pkg::PC_LO_W-1:0]};
				fps_pkg::OFS_STATUS: begin
					nxt_prdata                         = {20'h0, pc_ff};
					nxt_prdata[fps_pkg::STAT_PEND_BIT] = pc_lo_pend_ff;
					nxt_prdata[fps_pkg::STAT_EXEC_BIT] = exec_valid_ff;
				end
				default: nxt_pslverr = 1'b1;
			endcase
		end
		// a new write wins over the clear at the instruction boundary
		nxt_pc_lo_pend = pc_lo_pend_ff && !pend_taken;
		nxt_pc_lo_val  = pc_lo_val_ff;
		if (pc_lo_wr) begin
			nxt_pc_lo_pend = 1'b1;
			nxt_pc_lo_val  = pwdata[fps_pkg::PC_LO_W-1:0];
		end
	end

	// apb state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff   <= 32'h0;
			pready_ff   <= 1'b0;
			pslverr_ff    <= 1'b0;
			pc_lo_pend_ff <= 1'b0;
			pc_lo_val_ff  <= 8'h00;
		end else begin
			prdata_ff   <= nxt_prdata;
			pready_ff   <= nxt_pready;
			pslverr_ff  <= nxt_pslverr;
			pc_lo_pend_ff <= nxt_pc_lo_pend;
			pc_lo_val_ff  <= nxt_pc_lo_val;
		end
	end

	// ****************************************************************
	// fetch and execute sequencer
	// ****************************************************************
	fps_pkg::fps_seq_e        seq_ff;
	fps_pkg::fps_seq_e        nxt_seq;
	logic [fps_pkg::PC_W-1:0] nxt_pc;
	logic [fps_pkg::IR_W-1:0] prefetch_ff;
	logic [fps_pkg::IR_W-1:0] nxt_prefetch;
	logic [fps_pkg::IR_W-1:0] nxt_ir;
	logic                     nxt_exec_valid;
	logic                     nxt_pm_rd;
	logic                     nxt_int_ack;
	logic                     adv_norm;
	logic                     boot_ff;        // nothing fetched yet
	logic                     nxt_boot;

	// decisions are taken at the end of the last phase, after decode settled
	always_comb begin
		nxt_seq        = seq_ff;
		nxt_pc         = pc_ff;
		nxt_ir         = ir_ff;
		nxt_prefetch   = prefetch_ff;
		nxt_exec_valid = exec_valid_ff;
		nxt_int_ack    = 1'b0;
		stk_push       = 1'b0;
		stk_pop        = 1'b0;
		stk_din        = pc_ff;
		pend_taken     = 1'b0;
		adv_norm       = 1'b0;
		nxt_boot       = boot_ff;
		nxt_pm_rd      = ph_last;
		if (pm_rd_ff) begin
			nxt_prefetch = pm_data;
		end
		if (ph_last) begin
			nxt_boot = 1'b0;
			case (seq_ff)
				fps_pkg::FPS_INT2: begin
					stk_push       = 1'b1;
					nxt_pc         = INT_VEC;
					nxt_exec_valid = 1'b0;
					nxt_seq        = fps_pkg::FPS_RUN;
				end
				fps_pkg::FPS_RUN,
				fps_pkg::FPS_EXT2: begin
					nxt_seq = fps_pkg::FPS_RUN;
					if (boot_ff) begin
						nxt_exec_valid = 1'b0;
					end else if (seq_ff == fps_pkg::FPS_RUN && exec_valid_ff && dec_ext) begin
						nxt_seq = fps_pkg::FPS_EXT2;
					end else if (pc_lo_pend_ff) begin
						nxt_pc         = {pc_ff[fps_pkg::PC_W-1:fps_pkg::PC_LO_W], pc_lo_val_ff};
						pend_taken     = 1'b1;
						nxt_exec_valid = 1'b0;
					end else if (exec_valid_ff && (dec_jump || dec_call)) begin
						nxt_pc         = dec_target;
						stk_push       = dec_call;
						nxt_exec_valid = 1'b0;
					end else if (exec_valid_ff && dec_ret) begin
						stk_pop        = 1'b1;
						nxt_pc         = stk_top;
						nxt_exec_valid = 1'b0;
					end else if (exec_valid_ff && dec_skip) begin
						nxt_pc         = pc_ff + 12'h001;
						nxt_exec_valid = 1'b0;
					end else if (exec_valid_ff && int_req && !stk_full) begin
						nxt_int_ack    = 1'b1;
						// the dropped prefetch address stays as return point
						nxt_exec_valid = 1'b0;
						nxt_seq        = fps_pkg::FPS_INT2;
					end else begin
						adv_norm       = 1'b1;
						nxt_ir         = prefetch_ff;
						nxt_exec_valid = 1'b1;
						nxt_pc         = pc_ff + 12'h001;
					end
				end
				default: nxt_seq = fps_pkg::FPS_RUN;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_ff        <= fps_pkg::FPS_RUN;
			boot_ff       <= 1'b1;
			pc_ff         <= fps_pkg::RESET_VECTOR;
			ir_ff         <= 16'h0000;
			prefetch_ff   <= 16'h0000;
			exec_valid_ff <= 1'b0;
			pm_rd_ff      <= 1'b0;
			int_ack_ff    <= 1'b0;
		end else begin
			seq_ff        <= nxt_seq;
			boot_ff       <= nxt_boot;
			pc_ff         <= nxt_pc;
			ir_ff         <= nxt_ir;
			prefetch_ff   <= nxt_prefetch;
			exec_valid_ff <= nxt_exec_valid;
			pm_rd_ff      <= nxt_pm_rd;
			int_ack_ff    <= nxt_int_ack;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_vector_loaded;
		##4 (pc_ff == INT_VEC && !exec_valid_ff && seq_ff == fps_pkg::FPS_RUN);
	endsequence

	a_fetch_in_first: assert property (pm_rd_ff |-> ph_cnt == fps_pkg::PH_FETCH)
		else $error("fetch strobe outside fetch phase");
	a_pc_step_one: assert property (adv_norm |=> pc_ff == $past(pc_ff) + 12'h001
		&& exec_valid_ff && ir_ff == $past(prefetch_ff))
		else $error("normal advance did not step counter by one");
	a_jump_loads_target: assert property (ph_last
		&& (seq_ff == fps_pkg::FPS_EXT2 || !dec_ext)
		&& !pc_lo_pend_ff && exec_valid_ff && dec_jump
		|=> pc_ff == $past(dec_target) && !exec_valid_ff)
		else $error("jump did not load target with dummy cycle");
	a_low_in_page: assert property (pend_taken |=>
		pc_ff[11:8] == $past(pc_ff[11:8]) && pc_ff[7:0] == $past(pc_lo_val_ff)
		&& !exec_valid_ff)
		else $error("low byte write left page or skipped dummy");
	a_skip_dummy: assert property (ph_last && seq_ff == fps_pkg::FPS_RUN && exec_valid_ff
		&& !dec_ext && !pc_lo_pend_ff && !dec_jump && !dec_call && !dec_ret && dec_skip
		|=> pc_ff == $past(pc_ff) + 12'h001 && !exec_valid_ff)
		else $error("skip did not step past the dropped word");
	a_int_vector_two: assert property (int_ack_ff |-> s_vector_loaded)
		else $error("interrupt vector not loaded one cycle after ack");
	a_int_full_hold: assert property ($rose(int_ack_ff) |-> $past(!stk_full))
		else $error("interrupt acknowledged with full stack");
	a_ext_holds_ir: assert property (seq_ff == fps_pkg::FPS_EXT2 |->
		exec_valid_ff && $stable(ir_ff) && $stable(pc_ff))
		else $error("extended second cycle disturbed instruction");
	a_ret_restores: assert property (stk_pop |=> pc_ff == $past(stk_top))
		else $error("return did not restore counter");
	a_boot_holds_zero: assert property (boot_ff && ph_last |=>
		pc_ff == fps_pkg::RESET_VECTOR && !exec_valid_ff && !boot_ff)
		else $error("first cycle after reset left address zero");
	a_int_keeps_ret: assert property (int_ack_ff |-> $stable(pc_ff))
		else $error("interrupt acceptance moved the return address");
endmodule
`default_nettype wire

// ---- tb/fps_prog_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// program memory model
// ****************************************************************
module fps_prog_mem (
	input  wire logic [fps_pkg::PC_W-1:0] addr, // fetch address
	input  wire logic                     rd,   // fetch strobe
	output logic [fps_pkg::IR_W-1:0]      data  // fetched word
);
	// each word encodes its own address so every fetch can be traced;
	// off the strobe the bus shows a different pattern, never the last word
	always_comb begin
		data = rd ? {4'hA, addr} : {4'h5, ~addr};
	end
endmodule
`default_nettype wire

// ---- tb/tb_fetch_pc_stack_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_fetch_pc_stack_sequencer;
	localparam logic [4:0] EXT = 5'h10;
	localparam logic [4:0] BRA = 5'h08;
	localparam logic [4:0] CAL = 5'h04;
	localparam logic [4:0] RTN = 5'h02;
	localparam logic [4:0] SKP = 5'h01;
	logic        pclk       = 1'b0;
	logic        presetn    = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0000_0000;
	logic        dec_ext    = 1'b0;
	logic        dec_jump   = 1'b0;
	logic        dec_call   = 1'b0;
	logic        dec_ret    = 1'b0;
	logic        dec_skip   = 1'b0;
	logic [11:0] dec_target = 12'h000;
	logic        int_req    = 1'b0;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [11:0] pc_ff;
	logic        pm_rd_ff;
	logic [15:0] pm_data;
	logic [15:0] ir_ff;
	logic        exec_valid_ff;
	logic        int_ack_ff;
	logic [3:0]  phase_ff;
	logic [11:0] ret_q [0:6];
	int          num_errors   = 0;
	int          total_checks = 0;

	fps_fetch_seq dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
		.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .pc_ff(pc_ff),
		.pm_rd_ff(pm_rd_ff), .pm_data(pm_data), .ir_ff(ir_ff),
		.exec_valid_ff(exec_valid_ff), .int_ack_ff(int_ack_ff), .phase_ff(phase_ff),
		.dec_ext(dec_ext), .dec_jump(dec_jump), .dec_call(dec_call), .dec_ret(dec_ret),
		.dec_skip(dec_skip), .dec_target(dec_target), .int_req(int_req)
	);
	fps_prog_mem mem (.addr(pc_ff), .rd(pm_rd_ff), .data(pm_data));

	// 200 MHz system clock
	always #2.5 pclk = ~pclk;

	// ****************************************************************
	// shared helpers
	// ****************************************************************
	function automatic logic [15:0] wd(input logic [11:0] a);
		return {4'hA, a};
	endfunction

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// wait for the edge that closes an instruction cycle, bounded
	task automatic bnd();
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (phase_ff !== 4'b1000 && n < 20);
		if (n >= 20) begin
			num_errors++;
			tally_and_finish();
		end
		@(posedge pclk);
	endtask

	// one instruction cycle: decode d belongs to the word landing now
	task automatic issue(input logic [4:0] d, input logic [11:0] t);
		bnd();
		{dec_ext, dec_jump, dec_call, dec_ret, dec_skip} <= d;
		dec_target <= t;
		#1;
	endtask

	// branch-type op, its dummy slot, then the first real word
	task automatic branch(input logic [4:0] d, input logic [11:0] t, output logic [11:0] r);
		issue(d, t);
		r = pc_ff;
		issue(5'h00, 12'h000);
		chk("dummy_slot", exec_valid_ff, 1'b0); // dummy slot
		issue(5'h00, 12'h000);
		chk("valid_again", exec_valid_ff, 1'b1); // refill done
	endtask

	// apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_ff !== 1'b1 && n < 16);
		if (n >= 16) begin
			num_errors++;
			tally_and_finish();
		end
		r = prdata_ff;
		e = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_phases();
		for (int i = 1; i <= 8; i++) begin
			@(posedge pclk);
			#1;
			chk("phase", phase_ff, 4'b0001 << (i % 4)); // phase order
			chk("fetch_strobe", pm_rd_ff, (i % 4) == 0); // fetch in phase
		end
		for (int i = 0; i < 4 && exec_valid_ff !== 1'b1; i++) begin
			issue(5'h00, 12'h000);
		end
		chk("first_word", ir_ff, wd(12'h000)); // start at zero
		$display("test phases done");
	endtask

	task automatic t_flow();
		logic [11:0] p;
		logic [15:0] x;
		for (int i = 0; i < 4; i++) begin
			p = pc_ff;
			issue(5'h00, 12'h000);
			chk("pc_step", pc_ff, p + 12'h001); // one step
			chk("ir_word", ir_ff, wd(p)); // overlap
		end
		branch(BRA, 12'h3A5, p);
		chk("jump_word", ir_ff, wd(12'h3A5)); // target loaded
		branch(SKP, 12'h000, p);
		chk("skip_word", ir_ff, wd(p + 12'h001)); // prefetch dropped
		issue(EXT, 12'h000);
		p = pc_ff;
		x = ir_ff;
		issue(5'h00, 12'h000);
		chk("ext_hold", {ir_ff, 4'h0, pc_ff}, {x, 4'h0, p}); // two cycles
		issue(5'h00, 12'h000);
		chk("ext_next", ir_ff, wd(p)); // resumes
		$display("test flow done");
	endtask

	task automatic t_apb();
		logic [31:0] r;
		logic        e;
		logic [11:0] p;
		issue(5'h00, 12'h000);
		apb(1'b0, fps_pkg::OFS_PC_LO, 32'h0000_0000, r, e);
		chk("low_read", r[7:0], pc_ff[7:0]); // low byte
		issue(5'h00, 12'h000);
		apb(1'b0, fps_pkg::OFS_STATUS, 32'h0000_0000, r, e);
		chk("status_read", r[13:0], {2'h2, pc_ff}); // twelve bits
		issue(5'h00, 12'h000);
		p = pc_ff;
		apb(1'b1, fps_pkg::OFS_PC_LO, 32'h0000_005C, r, e);
		chk("low_wr_err", e, 1'b0); // writable
		issue(5'h00, 12'h000);
		chk("low_jump", {3'h0, exec_valid_ff, pc_ff}, {4'h0, p[11:8], 8'h5C}); // dummy
		issue(5'h00, 12'h000);
		chk("low_word", ir_ff, wd({p[11:8], 8'h5C})); // same page
		apb(1'b0, 8'h08, 32'h0000_0000, r, e);
		chk("unmapped_rd", {e, r}, {1'b1, 32'h0000_0000}); // nothing else visible
		issue(5'h00, 12'h000);
		p = pc_ff;
		apb(1'b1, 8'h08, 32'h0000_0011, r, e);
		chk("unmapped_wr", e, 1'b1); // refused
		issue(5'h00, 12'h000);
		chk("no_redirect", pc_ff, p + 12'h001); // plain step
		$display("test apb done");
	endtask

	task automatic t_stack();
		logic [11:0] r;
		for (int k = 0; k < 7; k++) begin
			branch(CAL, 12'h100 + 12'h010 * k[11:0], ret_q[k]);
		end
		@(posedge pclk);
		int_req <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			issue(5'h00, 12'h000);
			chk("ack_held", int_ack_ff, 1'b0); // full stack
		end
		@(posedge pclk);
		int_req <= 1'b0;
		for (int k = 6; k > 0; k--) begin
			branch(RTN, 12'h000, r);
			chk("ret_word", ir_ff, wd(ret_q[k])); // lifo
		end
		$display("test stack done");
	endtask

	task automatic t_intr();
		logic [11:0] r;
		logic [11:0] q;
		@(posedge pclk);
		int_req <= 1'b1;
		for (int n = 0; n < 4 && int_ack_ff !== 1'b1; n++) begin
			// the word after the executing one is dropped and must be resumed
			r = ir_ff[11:0] + 12'h001;
			issue(5'h00, 12'h000);
		end
		chk("int_ack", int_ack_ff, 1'b1); // accepted
		@(posedge pclk);
		int_req <= 1'b0;
		issue(5'h00, 12'h000);
		chk("vector", {exec_valid_ff, pc_ff}, {1'b0, fps_pkg::INT_VECTOR});
		issue(5'h00, 12'h000);
		chk("service", ir_ff, wd(fps_pkg::INT_VECTOR)); // two cycles
		branch(RTN, 12'h000, q);
		chk("int_return", ir_ff, wd(r)); // pushed
		$display("test interrupt done");
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (11) @(posedge pclk);
		#1;
		chk("rst_state", {pm_rd_ff, exec_valid_ff, phase_ff, pc_ff}, 18'h01000);
		@(posedge pclk);
		presetn <= 1'b1;
		t_phases();
		t_flow();
		t_apb();
		t_stack();
		t_intr();
		tally_and_finish();
	end
endmodule
`default_nettype wire
